// File: common/vsg_params.svh
`ifndef VSG_PARAMS_SVH
`define VSG_PARAMS_SVH

// Stream and pixel shape
`define VSG_DW 8
`define VSG_BPP 12'h003
`define VSG_PIX_BITS 24

// Frame geometry, in pixels and lines
`define VSG_CW 12
`define VSG_COLS 12'h140
`define VSG_HB 12'h028
`define VSG_HFP 12'h014
`define VSG_ROWS 12'h0F0
`define VSG_VB 12'h00A
`define VSG_VFP 12'h005

// Derived periods; horizontal position counts stream beats
`define VSG_HTOT (`VSG_COLS + `VSG_HB + `VSG_HFP)
`define VSG_VTOT (`VSG_ROWS + `VSG_VB + `VSG_VFP)
`define VSG_HBEATS (`VSG_HTOT * `VSG_BPP)
`define VSG_HACT_LO (`VSG_HB * `VSG_BPP)
`define VSG_HACT_HI ((`VSG_HB + `VSG_COLS) * `VSG_BPP)
`define VSG_VACT_LO `VSG_VB
`define VSG_VACT_HI (`VSG_VB + `VSG_ROWS)
`define VSG_H_ZERO 12'h000
`define VSG_H_ONE 12'h001

// Buffer
`define VSG_FIFO_DEPTH 32'h10
`define VSG_FIFO_LW 5
`define VSG_FIFO_ROOM 5'h0F

// Register port
`define VSG_AW 4
`define VSG_ADDR_CTRL 4'h0
`define VSG_ADDR_STATUS 4'h1
`define VSG_ADDR_LINE 4'h2
`define VSG_CTRL_EN_BIT 0
`define VSG_CTRL_CLR_BIT 1

`endif

// File: common/vsg_pkg.sv
package vsg_pkg;
  typedef enum logic [0:0] {
    VSG_HUNT = 1'b0,
    VSG_RUN = 1'b1
  } vsg_state_t;
endpackage

// File: hw/vsg_timing.sv
`timescale 1ns/100ps
`include "vsg_params.svh"
// How it works
// (R01) Pixel words go to the display unchanged, only syncs are added
// (R02) Timing locks when a beat carrying the first pixel marker arrives
// (R03) Source feeds pixels gaplessly, rows times columns per packet
// (R04) Beats per pixel is 1 or 3; width times beats equals pixel bits
// (R05) Columns set active pixels per line, rows set active lines per frame
// (R06) Horizontal blanking precedes active pixels, no data moves then
// (R07) Horizontal front porch follows active pixels, no data moves then
// (R08) Vertical blanking lines precede active lines, no data moves then
// (R09) Vertical front porch lines follow active lines, no data moves then
// (R10) Line period is columns plus blanking plus front porch pixels
// (R11) Frame period is rows plus blanking plus front porch lines
// (R12) Input data and display output share one stream width setting
// (R13) Ready is high exactly when a beat can be accepted
// (R14) Source presents a beat the cycle after ready; valid is ignored
// (R15) Source marks first and last pixel of every frame packet
// (R16) One line sync per line and one frame sync per frame
// (R17) Data enable is high only while active pixel data is shown
// (R18) Ready leads every active beat by one cycle
// (R19) Syncs are active low, one pixel long, at start of blanking

////////////////////////////////////////////////////////////////////////////////
module vsg_fifo #(
  parameter int WIDTH = `VSG_DW,
  parameter int DEPTH = `VSG_FIFO_DEPTH,
  parameter int LW = `VSG_FIFO_LW
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [LW-1:0] level
);
  // DEPTH must be a power of two; pointers wrap naturally
  localparam logic [LW-1:0] FULL = LW'(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [LW-2:0] wr_ptr_r;
  logic [LW-2:0] rd_ptr_r;
  logic [LW-1:0] count_r;
  logic [LW-1:0] count_nxt;
  wire wr_en = in_valid & in_ready;
  wire rd_en = out_valid & out_ready;

  assign in_ready = (count_r != FULL);
  assign out_valid = (count_r != {LW{1'b0}});
  assign out_data = mem_r[rd_ptr_r];
  assign level = count_r;
  assign count_nxt = (wr_en & !rd_en) ? count_r + 1'b1 :
                     (rd_en & !wr_en) ? count_r - 1'b1 : count_r;

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      wr_ptr_r <= wr_en ? wr_ptr_r + 1'b1 : wr_ptr_r;
      rd_ptr_r <= rd_en ? rd_ptr_r + 1'b1 : rd_ptr_r;
      count_r <= count_nxt;
    end
  end

  // Buffer never over- or underruns while the source keeps the rules
  AST_FIFO_NO_OVERRUN: assert property (@(posedge clk) disable iff (rst) // see R01 R13
    in_valid |-> in_ready)
    else $error("beat pushed into full buffer");
  AST_FIFO_NO_UNDERRUN: assert property (@(posedge clk) disable iff (rst) // see R01 R17
    out_ready |-> out_valid)
    else $error("pixel slot found buffer empty");
  AST_FIFO_COUNT: assert property (@(posedge clk) disable iff (rst)
    count_r <= FULL)
    else $error("buffer count beyond depth");
  AST_FIFO_LEVEL: assert property (@(posedge clk) disable iff (rst)
    (wr_en && !rd_en) |=> count_r == $past(count_r) + 1'b1)
    else $error("buffer count lost a push");
endmodule // vsg_fifo

////////////////////////////////////////////////////////////////////////////////
module vsg_timing (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`VSG_DW-1:0] sink_data,
  input wire logic sink_valid,
  input wire logic sink_first_pixel_marker,
  input wire logic sink_last_pixel_marker,
  output logic sink_ready,
  output logic [`VSG_DW-1:0] display_pixel_out,
  output logic line_sync_pulse_n,
  output logic frame_sync_pulse_n,
  output logic display_data_enable,
  input wire logic [`VSG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  function automatic logic h_act_f(input logic [`VSG_CW-1:0] pos);
    h_act_f = (pos >= `VSG_HACT_LO) && (pos < `VSG_HACT_HI); // see R05 R06 R07
  endfunction

  function automatic logic v_act_f(input logic [`VSG_CW-1:0] line);
    v_act_f = (line >= `VSG_VACT_LO) && (line < `VSG_VACT_HI); // see R05 R08 R09
  endfunction

  vsg_pkg::vsg_state_t st_r;
  vsg_pkg::vsg_state_t st_nxt;
  logic [`VSG_CW-1:0] h_r;
  logic [`VSG_CW-1:0] v_r;
  logic push_r;
  logic act_d1_r;
  logic enable_r;
  logic err_r;
  logic hs1_r;
  logic vs1_r;
  logic hs_r;
  logic vs_r;
  logic den_r;
  logic [`VSG_DW-1:0] pix_r;
  logic [31:0] rdata_r;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [`VSG_DW-1:0] fifo_data;
  logic [`VSG_FIFO_LW-1:0] fifo_level;

  ////////////////////////////////////////////////////////////////////////////
  // Position decode
  wire run = (st_r == vsg_pkg::VSG_RUN);
  wire hunt = (st_r == vsg_pkg::VSG_HUNT);
  wire h_last = (h_r == `VSG_HBEATS - `VSG_H_ONE); // see R10
  wire v_last = (v_r == `VSG_VTOT - `VSG_H_ONE); // see R11
  wire [`VSG_CW-1:0] h_step = h_last ? `VSG_H_ZERO : h_r + `VSG_H_ONE;
  wire [`VSG_CW-1:0] v_step = v_last ? `VSG_H_ZERO : v_r + `VSG_H_ONE;
  wire [`VSG_CW-1:0] v_ahead = h_last ? v_step : v_r;
  wire act_now = h_act_f(h_r) && v_act_f(v_r);
  wire act_ahead = h_act_f(h_step) && v_act_f(v_ahead);
  // One slot kept free for the beat already in flight
  wire room = (fifo_level < `VSG_FIFO_ROOM);
  wire lock = hunt && push_r && sink_first_pixel_marker; // see R02
  wire at_start = (h_r == `VSG_HACT_LO) && (v_r == `VSG_VACT_LO);
  wire misalign = run && push_r && sink_first_pixel_marker && !at_start;
  wire fifo_push = push_r && (run || sink_first_pixel_marker);
  wire pop = act_d1_r && fifo_out_valid;

  // While hunting, beats are drained and dropped until the first pixel
  assign sink_ready = enable_r && room && (hunt || act_ahead); // see R13 R18
  assign st_nxt = !enable_r ? vsg_pkg::VSG_HUNT :
                  lock ? vsg_pkg::VSG_RUN : st_r;

  ////////////////////////////////////////////////////////////////////////////
  // Frame timing
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= vsg_pkg::VSG_HUNT;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !enable_r) begin
      h_r <= `VSG_H_ZERO;
      v_r <= `VSG_H_ZERO;
    end else if (lock) begin
      h_r <= `VSG_HACT_LO + `VSG_H_ONE; // see R02
      v_r <= `VSG_VACT_LO;
    end else if (run) begin
      h_r <= h_step; // see R03 R10
      v_r <= v_ahead; // see R11
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      push_r <= 1'b0;
      act_d1_r <= 1'b0;
    end else begin
      push_r <= sink_ready; // see R14
      act_d1_r <= (run && act_now) || lock;
    end
  end

  vsg_fifo #(
    .WIDTH(`VSG_DW),
    .DEPTH(`VSG_FIFO_DEPTH),
    .LW(`VSG_FIFO_LW)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_data(sink_data),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_out_valid),
    .out_ready(act_d1_r),
    .level(fifo_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Display outputs, syncs delayed to line up with the pixel path
  always_ff @(posedge clk) begin
    if (rst) begin
      hs1_r <= 1'b1;
      vs1_r <= 1'b1;
      hs_r <= 1'b1;
      vs_r <= 1'b1;
      den_r <= 1'b0;
      pix_r <= '0;
    end else begin
      hs1_r <= !(run && (h_r < `VSG_BPP)); // see R16 R19
      vs1_r <= !(run && (v_r == `VSG_H_ZERO) && (h_r < `VSG_BPP)); // see R16 R19
      hs_r <= hs1_r;
      vs_r <= vs1_r;
      den_r <= pop; // see R17
      pix_r <= pop ? fifo_data : '0; // see R01 R12
    end
  end

  assign display_pixel_out = pix_r;
  assign line_sync_pulse_n = hs_r;
  assign frame_sync_pulse_n = vs_r;
  assign display_data_enable = den_r;

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  wire sel_ctrl = (reg_addr == `VSG_ADDR_CTRL);
  wire sel_status = (reg_addr == `VSG_ADDR_STATUS);
  wire sel_line = (reg_addr == `VSG_ADDR_LINE);
  wire wr_ctrl = reg_wr && sel_ctrl;
  wire err_clr = wr_ctrl && reg_wdata[`VSG_CTRL_CLR_BIT];
  wire [31:0] rd_val = sel_ctrl ? {31'h0, enable_r} :
                       sel_status ? {19'h0, fifo_level, 6'h00, err_r, run} :
                       sel_line ? {20'h0, v_r} : 32'h0;

  always_ff @(posedge clk) begin
    if (rst) begin
      enable_r <= 1'b0;
      err_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      enable_r <= wr_ctrl ? reg_wdata[`VSG_CTRL_EN_BIT] : enable_r;
      // A new misalignment wins over a clear in the same cycle
      err_r <= misalign || (err_r && !err_clr);
      rdata_r <= reg_rd ? rd_val : 32'h0;
    end
  end

  assign reg_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence seq_sync_low;
    !line_sync_pulse_n [*3] ##1 line_sync_pulse_n;
  endsequence

  sequence seq_lock_done;
    run && (h_r == `VSG_HACT_LO + `VSG_H_ONE) && (v_r == `VSG_VACT_LO);
  endsequence

  sequence seq_frame_low;
    !frame_sync_pulse_n [*3] ##1 frame_sync_pulse_n;
  endsequence

  sequence seq_hunt_two;
    hunt ##1 hunt;
  endsequence

  AST_SYNC_WIDTH: assert property ($fell(line_sync_pulse_n) |-> seq_sync_low) // see R19
    else $error("line sync pulse not one pixel long");
  AST_FRAME_WITH_LINE: assert property ($fell(frame_sync_pulse_n) |-> $fell(line_sync_pulse_n)) // see R16
    else $error("frame sync not at line start");
  AST_READY_AHEAD: assert property (run && sink_ready && !h_last |=> act_now) // see R18
    else $error("ready not one cycle ahead of active beat");
  AST_NO_BLANK_DATA: assert property (run && push_r |-> act_now) // see R06 R07 R08 R09
    else $error("beat taken outside active region");
  AST_PIXEL_PASS: assert property (pop |=> display_data_enable && (display_pixel_out == $past(fifo_data))) // see R01 R17
    else $error("pixel not passed unchanged");
  AST_DEN_BLANK: assert property (!act_d1_r |=> !display_data_enable) // see R17
    else $error("data enable during blanking");
  AST_LOCK: assert property (lock && enable_r |=> seq_lock_done) // see R02
    else $error("timing not aligned to first pixel");
  AST_HWRAP: assert property (run && h_last && enable_r |=> h_r == `VSG_H_ZERO) // see R10
    else $error("line period wrong");
  AST_VWRAP: assert property (run && h_last && v_last && enable_r |=> v_r == `VSG_H_ZERO) // see R11
    else $error("frame period wrong");
  AST_READY_ROOM: assert property (sink_ready |-> enable_r && room && fifo_in_ready) // see R13
    else $error("ready without room");
  AST_SHAPE: assert property ((`VSG_BPP == 12'h001 || `VSG_BPP == 12'h003) && (`VSG_DW * `VSG_BPP == `VSG_PIX_BITS)) // see R04 R12
    else $error("stream shape invalid");

  // Sync shape and place
  AST_FRAME_WIDTH: assert property ($fell(frame_sync_pulse_n) |-> seq_frame_low) // see R19
    else $error("frame sync pulse not one pixel long");
  AST_HUNT_SYNC_IDLE: assert property ( // see R16 R19
    seq_hunt_two |=> line_sync_pulse_n && frame_sync_pulse_n)
    else $error("sync pulse while hunting");
  AST_SYNC_AT_LINE_START: assert property ( // see R06 R19
    $fell(line_sync_pulse_n) |-> $past(h_r, 2) == `VSG_H_ZERO)
    else $error("line sync not at start of blanking");

  // Data only in active slots; source drained while hunting
  AST_DEN_IN_ACTIVE: assert property ( // see R06 R07 R08 R09 R17
    display_data_enable |-> $past(lock, 2) ||
      (h_act_f($past(h_r, 2)) && v_act_f($past(v_r, 2))))
    else $error("data enable outside active region");
  AST_PIX_IDLE_ZERO: assert property ( // see R17
    !display_data_enable |-> display_pixel_out == '0)
    else $error("pixel data outside data enable");
  AST_VLINE_READY: assert property ( // see R08 R09
    run && sink_ready |-> v_act_f(v_ahead))
    else $error("ready during vertical blanking");
  AST_HUNT_DRAIN: assert property ( // see R02 R13
    hunt && enable_r && room |-> sink_ready)
    else $error("hunting without draining the source");

  // Register port and error flag
  AST_RDATA_IDLE: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  AST_ERR_SET: assert property (misalign |=> err_r) // see R02
    else $error("misaligned first pixel not flagged");
endmodule // vsg_timing

// File: verif/vsg_source_model.sv
`timescale 1ns/100ps
`include "vsg_params.svh"
module vsg_source_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic sink_ready,
  input wire logic go,
  input wire logic stray,
  output logic [`VSG_DW-1:0] sink_data,
  output logic sink_valid,
  output logic sink_first_pixel_marker,
  output logic sink_last_pixel_marker
);
  localparam int LAST = `VSG_COLS * `VSG_ROWS * `VSG_BPP - 1;
  logic [`VSG_DW-1:0] exp_q[$];
  logic [`VSG_DW-1:0] d;
  int beat = 0;
  initial begin
    sink_data = '0;
    sink_valid = 1'b0;
    sink_first_pixel_marker = 1'b0;
    sink_last_pixel_marker = 1'b0;
  end
  // One beat after every ready cycle, never a gap; junk while not started
  always @(posedge clk) begin
    d = $urandom;
    if (!rst && sink_ready) begin
      sink_valid <= 1'b1;
      sink_data <= d;
      sink_first_pixel_marker <= (go && beat == 0) || stray;
      sink_last_pixel_marker <= go && beat == LAST;
      if (go) begin
        exp_q.push_back(d);
        beat = (beat == LAST) ? 0 : beat + 1;
      end
    end else begin
      // Line not driven: inverse of last value
      sink_valid <= 1'b0;
      sink_data <= ~sink_data;
      sink_first_pixel_marker <= 1'b0;
      sink_last_pixel_marker <= 1'b0;
    end
  end
endmodule // vsg_source_model

// File: verif/vsg_timing_bench.sv
`timescale 1ns/100ps
`include "vsg_params.svh"
module vsg_timing_bench;
  localparam int ACT = `VSG_COLS * `VSG_BPP;
  logic clk, rst, go, stray, sink_valid, fpm, lpm, sink_ready, lsn, fsn, den, reg_wr, reg_rd;
  logic [`VSG_DW-1:0] sink_data, pix;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic pl = 1'b1, pd = 1'b0, pr = 1'b0;
  int n_fail = 0, comparisons = 0, cyc = 0, pos = 0, low_n = 0, den_n = 0, rdy_n = 0;
  int rdy_at = 0, lines = 0;
  vsg_source_model vsg_source_model_i (.clk(clk), .rst(rst), .sink_ready(sink_ready), .go(go),
    .stray(stray), .sink_data(sink_data), .sink_valid(sink_valid),
    .sink_first_pixel_marker(fpm), .sink_last_pixel_marker(lpm));
  vsg_timing vsg_timing_i (.clk(clk), .rst(rst), .sink_data(sink_data), .sink_valid(sink_valid),
    .sink_first_pixel_marker(fpm), .sink_last_pixel_marker(lpm), .sink_ready(sink_ready),
    .display_pixel_out(pix), .line_sync_pulse_n(lsn), .frame_sync_pulse_n(fsn),
    .display_data_enable(den), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  task automatic complete_run;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(string nm, logic [3:0] a, logic [31:0] m, logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(nm, reg_rdata & m, exp);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Line monitor; pos counts cycles from line sync fall
  always @(posedge clk) begin
    cyc++;
    if (cyc > 50000) begin
      n_fail++;
      complete_run();
    end else if (!rst) begin
      pos++;
      if (pl && !lsn) begin
        if (lines > 0) begin
          check("line period", pos, `VSG_HBEATS);
          check("ready beats", rdy_n, ACT);
          check("frame sync", fsn, 1);
        end
        lines++;
        pos = 0;
        low_n = 0;
        rdy_n = 0;
      end
      if (!pl && lsn) check("sync width", low_n, `VSG_BPP);
      if (!lsn) low_n++;
      if (sink_ready) rdy_n++;
      if (sink_ready && !pr) rdy_at = pos;
      if (den && !pd && lines > 0) begin
        check("blanking", pos, `VSG_HACT_LO);
        check("ready lead", pos - rdy_at, 3);
      end
      if (!den && pd && lines > 0) check("active", den_n, ACT);
      if (den && !pd) den_n = 0;
      if (den) begin
        den_n++;
        check("pixel", pix, vsg_source_model_i.exp_q.pop_front());
      end else
        check("idle pixel", pix, 0);
      pl = lsn;
      pd = den;
      pr = sink_ready;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    go = 1'b0;
    stray = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    void'($urandom(97));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wr(`VSG_ADDR_STATUS, 32'hFFFFFFFF);
    wr(4'h7, 32'hFFFFFFFF);
    for (int a = 0; a < 8; a++) rd("reset reg", a[3:0], 32'hFFFFFFFF, 32'h0);
    check("idle ready", sink_ready, 0);
    check("idle sync", {lsn, fsn, den}, 3'h6);
    wr(`VSG_ADDR_CTRL, 32'h1);
    rd("ctrl", `VSG_ADDR_CTRL, 32'hFFFFFFFF, 32'h1);
    repeat (1 + $urandom % 8) @(posedge clk);
    go <= 1'b1;
    repeat (4) @(posedge clk);
    rd("locked", `VSG_ADDR_STATUS, 32'h1, 32'h1);
    rd("first line", `VSG_ADDR_LINE, 32'hFFF, `VSG_VACT_LO);
    wait (lines == 5);
    rd("line", `VSG_ADDR_LINE, 32'hFFF, `VSG_VACT_LO + 5);
    wait (lines == 8 && den);
    @(posedge clk);
    stray <= 1'b1;
    @(posedge clk);
    stray <= 1'b0;
    rd("stray marker", `VSG_ADDR_STATUS, 32'h2, 32'h2);
    wr(`VSG_ADDR_CTRL, 32'h3);
    rd("err clear", `VSG_ADDR_STATUS, 32'h3, 32'h1);
    wait (lines == 38);
    complete_run();
  end
endmodule // vsg_timing_bench
